// ===== common/adcsq_pkg.sv
// Purpose: shared constants and carriers for the converter serial sequencer
// Assumes: system clock 20 MHz, serial link clock from the host
// Notes: control word layout is a local choice, see field positions
package adcsq_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_SYS_HZ = 20000000;
   localparam int unsigned CONV_TIME_NS = 4600;
   localparam int unsigned CONV_CYCLES =
      (CONV_TIME_NS * (CLK_SYS_HZ / 1000000) + 999) / 1000;
   localparam int unsigned FRAME_BITS = 16;
   // ------------------------------------------------------------
   // control word fields
   // ------------------------------------------------------------
   localparam int unsigned CTL_START_POS = 0;
   localparam int unsigned CTL_TWO_WIRE_POS = 1;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [11:0] SAMPLE_RESET = 12'h000;

   typedef struct packed {
      logic start_req;
      logic two_wire;
   } adcsq_ctl_s;

   typedef enum logic [2:0] {
      ADCSQ_IDLE = 3'b001,
      ADCSQ_CONV = 3'b010,
      ADCSQ_DONE = 3'b100
   } adcsq_state_e;
endpackage : adcsq_pkg

// ===== src/adcsq_link.sv
// Purpose: serial link shifter on the host serial clock
// Assumes: link clock idles high (polarity 1), data sampled on rising
// Notes: frame reset by frame select high
`timescale 1ns/10ps
`default_nettype none
module adcsq_link
   import adcsq_pkg::*;
(
   input wire logic sclk_i,
   input wire logic rst_n_i,
   input wire logic frame_n_i,
   input wire logic din_i,
   input wire logic [15:0] result_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic [15:0] word_o,
   output logic word_tgl_o,
   output logic two_wire_o
);
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic [15:0] out_q;
   logic rd_phase_q;

   // ------------------------------------------------------------
   // input shift, 16th rising edge completes a word
   // ------------------------------------------------------------
   always_ff @(posedge sclk_i or posedge frame_n_i) begin
      if (frame_n_i) begin
         cnt_q <= 5'd0;
      end else if (cnt_q == 5'(FRAME_BITS - 1)) begin
         cnt_q <= 5'd0;
      end else begin
         cnt_q <= cnt_q + 5'd1;
      end
   end

   // data only, no reset needed
   always_ff @(posedge sclk_i) begin
      sh_q <= {sh_q[14:0], din_i};
   end

   // mode and direction outlive frames, so only the system reset clears them
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_o <= CTL_RESET;
         word_tgl_o <= 1'b0;
         two_wire_o <= 1'b0;
         rd_phase_q <= 1'b0;
      end else if (cnt_q == 5'(FRAME_BITS - 1)) begin
         if (!rd_phase_q) begin
            word_o <= {sh_q[14:0], din_i};
            word_tgl_o <= ~word_tgl_o;
            two_wire_o <= sh_q[CTL_TWO_WIRE_POS - 1];
         end
         // two-wire: direction flips at each 16th rising edge
         rd_phase_q <= two_wire_o ? ~rd_phase_q : 1'b0;
      end
   end

   // ------------------------------------------------------------
   // output shift on falling edge, leading zero first
   // ------------------------------------------------------------
   always_ff @(negedge sclk_i or posedge frame_n_i) begin
      if (frame_n_i) begin
         out_q <= 16'h0000;
         dout_o <= 1'b0;
      end else if (cnt_q == 5'h00) begin
         // reload at each slot start, also after a two-wire direction flip
         out_q <= {result_i[14:0], 1'b0};
         dout_o <= 1'b0;
      end else begin
         dout_o <= out_q[15];
         out_q <= {out_q[14:0], 1'b0};
      end
   end

   assign dout_oe_o = ~frame_n_i & (~two_wire_o | rd_phase_q);
endmodule : adcsq_link
`default_nettype wire

// ===== src/adcsq_seq.sv
// Purpose: conversion sequencing and host serial readout of the converter
// Assumes: host is serial master; link clock unrelated to clk_sys_i
// Notes: analog conversion modelled by a sample input and timer
//
// Notes on behaviour
// - two-wire mode uses serial clock and one bidirectional data line only.
// - conversion lasts 4.6 us; host waits at least that before reading.
// - conversion starts from start pin pulse or software start bit write.
// - busy output marks conversion; its end may serve as interrupt.
// - serial reads and writes accepted during conversion.
// - mode 2 frame writing start shifts out previous result meanwhile.
// - 16th rising edge switches line direction; 16 pulses per transfer.
// - first falling edge after frame select low shifts out leading zero.
// - busy falling edge clears software start bit; then it may be reset.
`timescale 1ns/10ps
`default_nettype none
module adcsq_seq
   import adcsq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic frame_n_i,
   input wire logic din_i,
   input wire logic conversion_start_n_i,
   input wire logic [11:0] sample_i,
   output logic din_o,
   output logic din_oe_o,
   output logic dout_o,
   output logic dout_oe_o,
   output logic busy_o,
   output logic sw_start_o,
   output logic two_wire_o
);
   adcsq_state_e state_q;
   logic [15:0] word_l;
   logic tgl_l;
   logic tw_l;
   logic ldo;
   logic loe;
   logic [2:0] tgl_s_q;
   logic [1:0] tw_s_q;
   logic [2:0] cs_s_q;
   logic [15:0] word_q;
   logic [15:0] result_q;
   logic [7:0] tmr_q;
   logic sw_q;
   logic hw_go;
   logic sw_go;
   logic lrst_n_q;
   logic new_q;
   logic [7:0] blen_q;

   adcsq_link u_link (
      .sclk_i(sclk_i),
      .rst_n_i(lrst_n_q),
      .frame_n_i(frame_n_i),
      .din_i(din_i),
      .result_i(result_q),
      .dout_o(ldo),
      .dout_oe_o(loe),
      .word_o(word_l),
      .word_tgl_o(tgl_l),
      .two_wire_o(tw_l)
   );

   // ------------------------------------------------------------
   // crossings into the system domain
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tgl_s_q <= 3'h0;
         tw_s_q <= 2'h0;
         cs_s_q <= 3'h7;
         word_q <= CTL_RESET;
         new_q <= 1'b0;
      end else begin
         tgl_s_q <= {tgl_s_q[1:0], tgl_l};
         new_q <= (tgl_s_q[2] != tgl_s_q[1]);
         tw_s_q <= {tw_s_q[0], tw_l};
         cs_s_q <= {cs_s_q[1:0], conversion_start_n_i};
         // word held stable for many cycles after toggle, safe to take
         if (tgl_s_q[2] != tgl_s_q[1]) begin
            word_q <= word_l;
         end
      end
   end

   assign hw_go = cs_s_q[2] & ~cs_s_q[1];
   assign sw_go = new_q & word_q[CTL_START_POS];

   // registered copy feeds the link reset; the gated link clock stands
   // still while it is released
   always_ff @(posedge clk_sys_i) begin
      lrst_n_q <= rst_n_i;
   end

   // helper: counts busy cycles for the length check
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         blen_q <= 8'h00;
      end else begin
         blen_q <= busy_o ? blen_q + 8'h01 : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // software start bit, cleared by busy falling edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sw_q <= 1'b0;
      end else if (state_q == ADCSQ_DONE) begin
         sw_q <= 1'b0;
      end else if (sw_go && state_q == ADCSQ_IDLE) begin
         sw_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // conversion timer and result
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= ADCSQ_IDLE;
         tmr_q <= 8'h00;
         result_q <= RESULT_RESET;
      end else begin
         case (state_q)
            ADCSQ_IDLE: begin
               if (hw_go || (sw_go && !sw_q)) begin
                  state_q <= ADCSQ_CONV;
                  tmr_q <= 8'(CONV_CYCLES - 1);
               end
            end
            ADCSQ_CONV: begin
               // link stays live here, reads return the previous result
               if (tmr_q == 8'h00) begin
                  state_q <= ADCSQ_DONE;
                  // limitation: a frame opening now may catch a torn result
                  result_q <= {4'h0, sample_i};
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            ADCSQ_DONE: begin
               state_q <= ADCSQ_IDLE;
            end
            default: begin
               state_q <= ADCSQ_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         sw_start_o <= 1'b0;
         two_wire_o <= 1'b0;
      end else begin
         busy_o <= (state_q == ADCSQ_CONV);
         sw_start_o <= sw_q;
         two_wire_o <= tw_s_q[1];
      end
   end

   // pin drivers follow the link clock domain directly
   assign din_o = ldo;
   assign din_oe_o = loe & tw_l;
   assign dout_o = ldo;
   assign dout_oe_o = loe & ~tw_l;

   a_busy_len: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(busy_o) |-> busy_o [*8])
      else $error("busy too short");
   a_conv_len: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(busy_o) |-> blen_q == 8'(CONV_CYCLES))
      else $error("busy length wrong");
   a_sw_clear: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(busy_o) |-> ##[0:2] !sw_start_o)
      else $error("start bit not cleared");
   a_done_clear: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_q == ADCSQ_DONE) |=> !sw_q)
      else $error("start bit kept after conversion");
   a_hw_start: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (hw_go && state_q == ADCSQ_IDLE) |-> ##2 busy_o)
      else $error("start pulse ignored");
   a_sw_busy: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(sw_start_o) |-> busy_o)
      else $error("start bit without conversion");
   a_pin_excl: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !(din_oe_o && dout_oe_o))
      else $error("both data pins driven");
endmodule : adcsq_seq
`default_nettype wire

// ===== tb/adcsq_host.sv
// Purpose: host serial master model, mode 2 framing
// Assumes: gated link clock, 32 ns period, idles high
// Notes: data line shows inverse of last bit when idle
`timescale 1ns/10ps
`default_nettype none
module adcsq_host (
   input wire logic dout_i,
   output logic sclk_o,
   output logic frame_n_o,
   output logic din_o
);
   initial begin
      sclk_o = 1'b1;
      frame_n_o = 1'b1;
      din_o = 1'b0;
   end
   // hold keeps select low after the frame, as a two-wire host does
   task automatic xfer(input logic [15:0] tx, input logic hold,
      output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      frame_n_o = 1'b0;
      #16;
      for (i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o = tx[i];
         #16;
         sclk_o = 1'b1;
         rx = {rx[14:0], dout_i};
         #16;
      end
      if (!hold) begin
         frame_n_o = 1'b1;
      end
      din_o = ~din_o;
   endtask : xfer
endmodule : adcsq_host
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: host model drives the link; 20 MHz system clock
// Notes: expected results built from the sample inputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin fails++; \
   $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb_top;
   import adcsq_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cs_n = 1'b1;
   logic [11:0] sample = 12'h000;
   logic sclk, frame_n, host_din, din_o, din_oe_o, dout_o, dout_oe_o;
   logic busy_o, sw_start_o, two_wire_o;
   logic [15:0] rx;
   wire logic din_line;
   wire logic host_rx;
   int fails = 0;
   int cmp_count = 0;
   int n;
   assign din_line = din_oe_o ? din_o : host_din;
   // host reads the data line in two-wire mode, the data output otherwise
   assign host_rx = dout_oe_o ? dout_o : din_line;
   adcsq_seq i_adcsq_seq (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .sclk_i(sclk), .frame_n_i(frame_n), .din_i(din_line),
      .conversion_start_n_i(cs_n), .sample_i(sample), .din_o(din_o),
      .din_oe_o(din_oe_o), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
      .busy_o(busy_o), .sw_start_o(sw_start_o), .two_wire_o(two_wire_o));
   adcsq_host i_adcsq_host (.dout_i(host_rx), .sclk_o(sclk),
      .frame_n_o(frame_n), .din_o(host_din));
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // bounded wait; n holds cycles spent
   task automatic wait_busy(input logic v);
      n = 0;
      while (busy_o !== v && n < 400) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 400) begin
         fails++;
         report_and_stop();
      end
   endtask : wait_busy
   task automatic frame(input logic [15:0] tx);
      @(posedge clk_sys_i);
      #7;
      i_adcsq_host.xfer(tx, 1'b0, rx);
      repeat (8) @(posedge clk_sys_i); // crossing settles
   endtask : frame
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_hw_start();
      sample <= 12'hA5C;
      @(posedge clk_sys_i) cs_n <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      cs_n <= 1'b1;
      wait_busy(1'b1);
      `CHK("start lag", 1'b1, n <= 8)
      repeat (20) @(posedge clk_sys_i);
      cs_n <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      cs_n <= 1'b1;
      wait_busy(1'b0);
      // extra pulse mid-conversion must not stretch busy
      `CHK("busy len", CONV_CYCLES, n + 23)
      frame(16'h0000);
      `CHK("hw result", {4'h0, 12'hA5C}, rx)
      `CHK("no start", 1'b0, busy_o)
   endtask : t_hw_start
   task automatic t_sw_start();
      sample <= 12'h3C1;
      frame(16'h0001);
      `CHK("sw bit", 1'b1, sw_start_o)
      `CHK("sw busy", 1'b1, busy_o)
      frame(16'h0000);
      `CHK("prev result", {4'h0, 12'hA5C}, rx)
      wait_busy(1'b0);
      repeat (2) @(posedge clk_sys_i);
      `CHK("sw clear", 1'b0, sw_start_o)
      frame(16'h0000);
      `CHK("sw result", {4'h0, 12'h3C1}, rx)
   endtask : t_sw_start
   task automatic t_two_wire();
      sample <= 12'h5A3;
      frame(16'h0002);
      `CHK("two wire", 1'b1, two_wire_o)
      `CHK("tw no start", 1'b0, busy_o)
      // select held low from here: write, wait, read
      i_adcsq_host.xfer(16'h0003, 1'b1, rx);
      repeat (8) @(posedge clk_sys_i);
      `CHK("tw line out", 1'b1, din_oe_o)
      wait_busy(1'b0);
      i_adcsq_host.xfer(16'h0000, 1'b1, rx);
      repeat (2) @(posedge clk_sys_i);
      `CHK("tw result", {4'h0, 12'h5A3}, rx)
      `CHK("tw line in", 1'b0, din_oe_o)
      @(posedge clk_sys_i) rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK("rst two wire", 1'b0, two_wire_o)
      @(posedge clk_sys_i) rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      `CHK("rst busy 2", 1'b0, busy_o)
      frame(16'h0000);
      `CHK("rst result", RESULT_RESET, rx)
   endtask : t_two_wire
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      `CHK("rst busy", 1'b0, busy_o)
      `CHK("rst sw", 1'b0, sw_start_o)
      t_hw_start();
      t_sw_start();
      t_two_wire();
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
